//--- design/sac_map.vh
// constants for the serial converter control block
// Operation
// (R1) direction bit picks MSB or LSB first next
// (R2) format 0 gives unsigned binary result
// (R3) format 1 inverts MSB for two's complement
// (R4) format applies to following conversion only
// (R5) end flag high at reset and sampling
// (R6) end flag drops after last falling edge
// (R7) end flag rises when result latched
// (R8) first bit shown at end flag rise
// (R9) first bit shown at debounced select fall
// (R10) serial output forced zero while converting
// (R11) each falling edge advances to next bit
// (R12) 12-bit result, MSB justified, pad or truncate
// (R13) select high floats output, then inhibits clock
// (R14) select low resets after debounce time
// (R15) host keeps shift clock low after reset
// (R16) select abort keeps previous result buffered
// (R17) address 1110 enters power down at edge four
// (R18) power down skips conversion, serial stays active
// (R19) power on starts in power down
// (R20) address codes pick inputs and test voltages
// (R21) sampling from edge four to last edge
// (R22) one trial bit per step, MSB first
// (R23) length 00 or 10 gives 12 clocks
// (R24) length 11 gives 16, 01 gives 8
// (R25) command MSB first, top four bits address
// (R26) conversion is fixed steps of clock cycles
`ifndef SAC_MAP_VH
`define SAC_MAP_VH
`define SAC_CLK_NS      10
`define SAC_RES_W       12
`define SAC_CMD_W       8
`define SAC_ADDR_PD     4'he
`define SAC_LEN_8       2'b01
`define SAC_LEN_16      2'b11
`define SAC_BITS_8      5'h08
`define SAC_BITS_12     5'h0c
`define SAC_BITS_16     5'h10
`define SAC_PAD_BITS    5'h04
`define SAC_SAMPLE_EDGE 5'h04
`define SAC_LEN_RISE    5'h05
`define SAC_CS_DEB_NS   200
`define SAC_CS_DEB_CYC  ((`SAC_CS_DEB_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_STEP_NS     800
`define SAC_STEP_CYC    (`SAC_STEP_NS / `SAC_CLK_NS)
`define SAC_FIFO_DEPTH  16
`define SAC_FIFO_AW     4
`endif

//--- design/sac_top.v
// serial converter control: result fifo and top level
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_fifo #(
  parameter W  = 12,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         reset_i,
  // fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0]   count_ff;
  wire         do_wr;
  wire         do_rd;

  assign in_ready_o  = (count_ff != D[AW:0]);
  assign out_valid_o = (count_ff != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_ff];
  assign do_wr       = in_valid_i & in_ready_o;
  assign do_rd       = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // sac_fifo

module sac_top #(
  parameter DEB_CYC  = `SAC_CS_DEB_CYC,
  parameter STEP_CYC = `SAC_STEP_CYC,
  parameter DEPTH    = `SAC_FIFO_DEPTH
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // serial pins from host
  input  wire        cs_n_i,
  input  wire        io_clk_i,
  input  wire        data_in_i,
  // serial output pin
  output wire        data_out_o,
  output wire        data_out_oe_o,
  // status pin
  output wire        eoc_o,
  // analogue array control
  input  wire        cmp_below_i,
  output wire        sample_o,
  output wire [3:0]  mux_sel_o,
  output wire [11:0] trial_o,
  output wire        power_down_o
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_CONV  = 2'b01;
  localparam ST_LATCH = 2'b10;

  // pin synchronisers
  reg        cs_s1_ff;
  reg        cs_s2_ff;
  reg        ck_s1_ff;
  reg        ck_s2_ff;
  reg        ck_d_ff;
  reg        din_s1_ff;
  reg        din_s2_ff;
  reg        cmp_s1_ff;
  reg        cmp_s2_ff;
  // chip select debounce
  reg        cs_deb_ff;
  reg [15:0] deb_cnt_ff;
  // control state
  reg [1:0]  state_ff;
  reg        pd_ff;
  reg        eoc_ff;
  reg        sample_ff;
  reg        dout_ff;
  reg        oe_ff;
  reg [4:0]  fall_ff;
  reg [4:0]  rise_ff;
  reg [7:0]  cmd_ff;
  reg [1:0]  len_ff;
  reg [3:0]  mux_ff;
  reg [11:0] res_ff;
  reg        res_lsbf_ff;
  reg        fmt_conv_ff;
  reg [11:0] trial_ff;
  reg [3:0]  step_ff;
  reg [15:0] step_cnt_ff;
  reg        push_ff;
  reg [11:0] push_data_ff;

  wire        ck_rise;
  wire        ck_fall;
  wire        cs_deb_fall;
  wire [4:0]  nxt_fall;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [11:0] fifo_out_data;
  wire        pop;
  wire        push_go;

  // transfer length in clocks from length field
  function [4:0] len_bits;
    input [1:0] ln;
    begin
      case (ln)
        `SAC_LEN_8:  len_bits = `SAC_BITS_8;   // [R24]
        `SAC_LEN_16: len_bits = `SAC_BITS_16;  // [R24]
        default:     len_bits = `SAC_BITS_12;  // [R23]
      endcase
    end
  endfunction

  // serial bit k of a stored result
  function out_bit;
    input [11:0] r;
    input        lsbf;
    input [1:0]  ln;
    input [4:0]  k;
    reg   [4:0]  j;
    begin
      out_bit = 1'b0;
      j       = 5'h00;
      if (!lsbf) begin
        if (k < `SAC_BITS_12) begin  // [R12]
          j       = 5'h0b - k;
          out_bit = r[j[3:0]];
        end
      end else begin
        case (ln)
          `SAC_LEN_16: begin
            if (k >= `SAC_PAD_BITS && k < `SAC_BITS_16) begin  // [R12]
              j       = k - `SAC_PAD_BITS;
              out_bit = r[j[3:0]];
            end
          end
          `SAC_LEN_8: begin
            if (k < `SAC_BITS_8) begin  // [R12]
              j       = k + `SAC_PAD_BITS;
              out_bit = r[j[3:0]];
            end
          end
          default: begin
            if (k < `SAC_BITS_12) begin
              out_bit = r[k[3:0]];
            end
          end
        endcase
      end
    end
  endfunction

  assign ck_rise     = ck_s2_ff & ~ck_d_ff;
  assign ck_fall     = ~ck_s2_ff & ck_d_ff;
  assign cs_deb_fall = cs_deb_ff & ~cs_s2_ff & (deb_cnt_ff == DEB_CYC[15:0] - 16'h0001);
  assign nxt_fall    = fall_ff + 5'h01;
  assign pop         = (state_ff == ST_LATCH);
  // a cut conversion leaves no stale word queued
  assign push_go     = push_ff & ~cs_deb_fall;  // [R16]

  sac_fifo #(
    .W  (`SAC_RES_W),
    .D  (DEPTH),
    .AW (`SAC_FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_go),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_ff),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

  always @(posedge clk_i) begin
    if (reset_i) begin
      cs_s1_ff  <= 1'b1;
      cs_s2_ff  <= 1'b1;
      ck_s1_ff  <= 1'b0;
      ck_s2_ff  <= 1'b0;
      ck_d_ff   <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff  <= cs_n_i;
      cs_s2_ff  <= cs_s1_ff;
      ck_s1_ff  <= io_clk_i;
      ck_s2_ff  <= ck_s1_ff;
      ck_d_ff   <= ck_s2_ff;
      din_s1_ff <= data_in_i;
      din_s2_ff <= din_s1_ff;
      cmp_s1_ff <= cmp_below_i;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // select debounce, both directions
  always @(posedge clk_i) begin
    if (reset_i) begin
      cs_deb_ff  <= 1'b1;
      deb_cnt_ff <= 16'h0000;
      oe_ff      <= 1'b0;
    end else begin
      oe_ff <= ~cs_s2_ff;  // [R13]
      if (cs_s2_ff == cs_deb_ff) begin
        deb_cnt_ff <= 16'h0000;
      end else if (deb_cnt_ff == DEB_CYC[15:0] - 16'h0001) begin
        deb_cnt_ff <= 16'h0000;
        cs_deb_ff  <= cs_s2_ff;  // [R13] [R14]
      end else begin
        deb_cnt_ff <= deb_cnt_ff + 16'h0001;
      end
    end
  end

  // sequencer: shift, sample, convert, latch
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_ff     <= ST_IDLE;
      pd_ff        <= 1'b1;  // [R19]
      eoc_ff       <= 1'b1;  // [R5]
      sample_ff    <= 1'b0;
      dout_ff      <= 1'b0;
      fall_ff      <= 5'h00;
      rise_ff      <= 5'h00;
      cmd_ff       <= 8'h00;
      len_ff       <= 2'b00;
      mux_ff       <= 4'h0;
      res_ff       <= 12'h000;
      res_lsbf_ff  <= 1'b0;
      fmt_conv_ff  <= 1'b0;
      trial_ff     <= 12'h000;
      step_ff      <= 4'h0;
      step_cnt_ff  <= 16'h0000;
      push_ff      <= 1'b0;
      push_data_ff <= 12'h000;
    end else if (cs_deb_fall) begin
      // abort keeps last latched result
      state_ff    <= ST_IDLE;  // [R14] [R16]
      eoc_ff      <= 1'b1;
      sample_ff   <= 1'b0;
      fall_ff     <= 5'h00;
      rise_ff     <= 5'h00;
      push_ff     <= 1'b0;
      step_cnt_ff <= 16'h0000;
      trial_ff    <= 12'h000;
      step_ff     <= 4'h0;
      dout_ff     <= out_bit(res_ff, res_lsbf_ff, len_ff, 5'h00);  // [R9]
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (!cs_deb_ff) begin  // [R13]
            if (ck_rise && rise_ff < `SAC_BITS_8) begin
              cmd_ff  <= {cmd_ff[6:0], din_s2_ff};  // [R25]
              rise_ff <= rise_ff + 5'h01;
              if (rise_ff == `SAC_LEN_RISE) begin
                len_ff <= {cmd_ff[0], din_s2_ff};  // [R24]
              end
            end
            if (ck_fall) begin
              fall_ff <= nxt_fall;
              dout_ff <= out_bit(res_ff, res_lsbf_ff, len_ff, nxt_fall);  // [R11]
              if (nxt_fall == `SAC_SAMPLE_EDGE) begin
                if (cmd_ff[3:0] == `SAC_ADDR_PD) begin
                  pd_ff <= 1'b1;  // [R17]
                end else begin
                  pd_ff     <= 1'b0;  // [R19]
                  sample_ff <= 1'b1;  // [R21] [R5]
                  mux_ff    <= cmd_ff[3:0];  // [R20] [R25]
                end
              end
              if (nxt_fall == len_bits(len_ff)) begin
                res_lsbf_ff <= cmd_ff[1];  // [R1]
                fmt_conv_ff <= cmd_ff[0];  // [R4]
                fall_ff     <= 5'h00;
                rise_ff     <= 5'h00;
                if (!pd_ff) begin
                  state_ff    <= ST_CONV;
                  eoc_ff      <= 1'b0;  // [R6] [R23]
                  sample_ff   <= 1'b0;  // [R21]
                  dout_ff     <= 1'b0;  // [R10]
                  trial_ff    <= 12'h800;
                  step_ff     <= 4'hb;
                  step_cnt_ff <= 16'h0000;
                end else begin
                  // power down: no conversion, old result stays
                  dout_ff <= out_bit(res_ff, cmd_ff[1], len_ff, 5'h00);  // [R18]
                end
              end
            end
          end
        end
        ST_CONV: begin
          if (push_ff) begin
            if (fifo_in_ready) begin
              push_ff  <= 1'b0;
              state_ff <= ST_LATCH;
            end
          end else if (step_cnt_ff == STEP_CYC[15:0] - 16'h0001) begin
            step_cnt_ff        <= 16'h0000;  // [R26]
            trial_ff[step_ff]  <= cmp_s2_ff;  // [R22]
            if (step_ff != 4'h0) begin
              trial_ff[step_ff - 4'h1] <= 1'b1;
              step_ff                  <= step_ff - 4'h1;
            end else begin
              push_ff      <= 1'b1;
              push_data_ff <= {trial_ff[11] ^ fmt_conv_ff, trial_ff[10:1], cmp_s2_ff};  // [R2] [R3]
            end
          end else begin
            step_cnt_ff <= step_cnt_ff + 16'h0001;
          end
        end
        ST_LATCH: begin
          if (fifo_out_valid) begin
            res_ff   <= fifo_out_data;
            eoc_ff   <= 1'b1;  // [R7]
            state_ff <= ST_IDLE;
            fall_ff  <= 5'h00;
            rise_ff  <= 5'h00;
            dout_ff  <= out_bit(fifo_out_data, res_lsbf_ff, len_ff, 5'h00);  // [R8]
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // outputs straight from flops
  assign data_out_o    = dout_ff;
  assign data_out_oe_o = oe_ff;
  assign eoc_o         = eoc_ff;
  assign sample_o      = sample_ff;
  assign mux_sel_o     = mux_ff;
  assign trial_o       = trial_ff;
  assign power_down_o  = pd_ff;
endmodule // sac_top

//--- bench/sac_top_asserts.sv
// concurrent checks on the converter control top level
`timescale 1ns/1ps
module sac_top_asserts #(
  parameter DEB_CYC  = 2,
  parameter STEP_CYC = 8
) (
  // clock and reset
  input wire        clk_i,
  input wire        reset_i,
  // watched pins
  input wire        cs_n_i,
  input wire        data_out_o,
  input wire        data_out_oe_o,
  input wire        eoc_o,
  input wire        sample_o,
  input wire [3:0]  mux_sel_o,
  input wire [11:0] trial_o,
  input wire        power_down_o
);
  localparam int CONV_MAX = 12 * STEP_CYC + 8;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_reset_state: assert property (disable iff (1'b0)
    reset_i |=> eoc_o && power_down_o && !data_out_oe_o)
    else $error("reset state wrong");
  a_conv_zero: assert property (!eoc_o |-> !data_out_o)
    else $error("serial output not zero while converting");
  a_sample_high: assert property (sample_o |-> eoc_o)
    else $error("end flag low while sampling");
  a_switch_open: assert property ($fell(eoc_o) |-> !sample_o && $past(sample_o))
    else $error("sampling not ended at conversion start");
  a_trial_start: assert property ($fell(eoc_o) |-> trial_o == 12'h800)
    else $error("first trial code wrong");
  a_conv_min: assert property ($fell(eoc_o) |-> !eoc_o [*8])
    else $error("conversion too short");
  a_conv_bound: assert property ($fell(eoc_o) |-> ##[1:CONV_MAX] eoc_o)
    else $error("conversion did not end");
  a_float_out: assert property (cs_n_i [*5] |-> !data_out_oe_o)
    else $error("output driven while deselected");
  a_drive_sel: assert property (!cs_n_i [*8] |-> data_out_oe_o)
    else $error("output not driven while selected");
  a_pd_idle: assert property (power_down_o |-> eoc_o)
    else $error("conversion during power down");
  a_addr_hold: assert property (!eoc_o |-> $stable(mux_sel_o))
    else $error("address changed during conversion");

  cover property ($fell(eoc_o));
  cover property ($rose(power_down_o));
  cover property ($fell(data_out_oe_o));
endmodule // sac_top_asserts

bind sac_top sac_top_asserts #(.DEB_CYC(DEB_CYC), .STEP_CYC(STEP_CYC)) sac_top_asserts_inst (
  .clk_i, .reset_i, .cs_n_i, .data_out_o, .data_out_oe_o, .eoc_o,
  .sample_o, .mux_sel_o, .trial_o, .power_down_o);

//--- bench/sac_host.sv
// host serial port model: select, shift clock and command bits
`timescale 1ns/1ps
module sac_host (
  // host pins
  output reg  cs_n_o,
  output reg  io_clk_o,
  output reg  data_in_o,
  input  wire data_out_i,
  input  wire data_out_oe_i
);
  reg  last_bit;
  // released line reads inverse of last value
  wire seen = data_out_oe_i ? data_out_i : ~last_bit;

  initial begin
    cs_n_o = 1'b1;
    io_clk_o = 1'b0;
    data_in_o = 1'b0;
    last_bit = 1'b0;
  end

  task sel(input lo);
    begin
      cs_n_o = ~lo;
      #400;  // shift clock idle low past debounce
    end
  endtask

  task xfer(input [7:0] cmd, input integer n, output [15:0] rx);
    integer i;
    begin
      rx = 16'h0;
      #1.25;  // keep pin edges off both clock edges
      for (i = 0; i < n; i = i + 1) begin  // full length always
        data_in_o = (i < 8) ? cmd[7-i] : 1'b0;
        #62.5 io_clk_o = 1'b1;
        rx = {rx[14:0], seen};
        last_bit = seen;
        #62.5 io_clk_o = 1'b0;
      end
    end
  endtask
endmodule // sac_host

//--- bench/sac_top_bench.sv
// bench for the serial converter control block
`timescale 1ns/1ps
module sac_top_bench;
  reg         clk_i;
  reg         reset_i;
  reg         cmp_below;
  reg         lsb_last;
  reg  [15:0] rx;
  integer     err_total;
  integer     num_checks;
  integer     k;
  wire        cs_n;
  wire        io_clk;
  wire        din;
  wire        dout;
  wire        oe;
  wire        eoc;
  wire        smp;
  wire        pd;
  wire [3:0]  mux;
  wire [11:0] trial;

  sac_top #(.DEB_CYC(2), .STEP_CYC(8)) sac_top_inst (
    .clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .io_clk_i(io_clk),
    .data_in_i(din), .data_out_o(dout), .data_out_oe_o(oe), .eoc_o(eoc),
    .cmp_below_i(cmp_below), .sample_o(smp), .mux_sel_o(mux), .trial_o(trial),
    .power_down_o(pd));

  sac_host sac_host_inst (
    .cs_n_o(cs_n), .io_clk_o(io_clk), .data_in_o(din),
    .data_out_i(dout), .data_out_oe_i(oe));

  // input level seen by the array for each address
  function [11:0] tgt(input [3:0] a);
    tgt = a == 4'hb ? 12'h800 : a == 4'hc ? 12'h000 : a == 4'hd ? 12'hfff : {a, 8'ha3};
  endfunction

  // expected stream, first bit sent in bit n-1
  function [15:0] fmt_s(input [11:0] w, input [1:0] ln, input lsb);
    reg [15:0] v;
    integer n, i;
    begin
      n = ln == 2'b01 ? 8 : ln == 2'b11 ? 16 : 12;
      v = ln == 2'b01 ? {8'h0, w[11:4]} : ln == 2'b11 ? {w, 4'h0} : {4'h0, w};
      fmt_s = v;
      if (lsb)
        for (i = 0; i < n; i = i + 1) fmt_s[i] = v[n-1-i];
    end
  endfunction

  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) cmp_below <= (trial <= tgt(mux));

  task results;
    begin
      if (err_total == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  task wait_eoc;
    begin
      k = 0;
      while (eoc !== 1'b1 && k < 300) begin
        @(negedge clk_i);
        k = k + 1;
      end
      if (eoc !== 1'b1) begin
        chk(eoc, 1'b1);
        results;
      end
    end
  endtask

  task run(input [7:0] cmd, input [11:0] w, input ab);
    integer n;
    begin
      n = cmd[3:2] == 2'b01 ? 8 : cmd[3:2] == 2'b11 ? 16 : 12;
      sac_host_inst.xfer(cmd, n, rx);
      chk(rx, fmt_s(w, cmd[3:2], lsb_last));
      lsb_last = cmd[1];
      repeat (8) @(negedge clk_i);
      if (cmd[7:4] == 4'he) begin
        chk({pd, eoc}, 2'b11);
      end else begin
        chk({mux, pd, eoc, smp}, {cmd[7:4], 3'b000});
        if (ab) begin
          sac_host_inst.sel(1'b0);
          chk(oe, 1'b0);
          sac_host_inst.sel(1'b1);
          chk(eoc, 1'b1);
        end else begin
          wait_eoc;
        end
      end
    end
  endtask

  initial begin
    #200000;
    chk(1'b0, 1'b1);
    results;
  end

  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    cmp_below = 1'b0;
    lsb_last = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    chk({eoc, pd, oe}, 3'b110);
    sac_host_inst.sel(1'b1);
    run(8'h50, 12'h000, 1'b0);
    run(8'hdf, 12'h5a3, 1'b0);
    run(8'hcd, 12'hfff ^ 12'h800, 1'b0);
    run(8'h54, 12'h000 ^ 12'h800, 1'b0);
    run(8'he2, 12'h5a3, 1'b0);
    run(8'h30, 12'h5a3, 1'b1);
    run(8'hb0, 12'h5a3, 1'b0);
    run(8'h18, 12'h800, 1'b0);
    results;
  end
endmodule // sac_top_bench
